// file: design/ftm_modulator.sv
// Top of the FSK tone modulator with mode control and carrier qualifier.
`include "ftm_consts.svh"
`default_nettype none
// How it works
// R1 - The tone divisor is picked from the transmit bit and the originate/answer select.
// R2 - The divider emits a tick at sixteen times the transmitted tone frequency.
// R3 - Each divider tick advances a four-bit slot counter through one sine period.
// R4 - The slot counter is looked up in the sine table and the code goes to the DAC.
// R5 - A change of transmit bit only changes the next divisor and never resets the phase.
// R6 - Carrier sense goes low only after the carrier stayed above threshold for the delay.
// R7 - All internal rates come from one 3.58 MHz oscillator tick made from the system clock.
// R8 - Control logic picks originate, answer or loopback and sets both paths to match.
// R9 - Loopback and squelch together put the block in low-power shutdown.
// R10 - The line driver is disabled while squelch is asserted.
// R11 - Loopback select without squelch enters loopback; with loopback select low the select input picks originate or answer.
// R12 - Divisors give 1270/1070 Hz in originate and 2225/2025 Hz in answer.
module ftm_modulator
   import ftm_pkg::*;
#(
   parameter int SYS_HZ = `FTM_SYS_HZ,
   parameter int OSC_HZ = `FTM_OSC_HZ
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic tx_bit,
   input wire logic orig_sel,
   input wire logic loopback_sel,
   input wire logic driver_squelch,
   input wire logic carrier_above,
   input wire logic [15:0] carrier_delay_cap,
   output logic [7:0] dac_code,
   output logic line_drive_en,
   output logic tx_band_high,
   output logic rx_band_high,
   output logic loop_active,
   output logic power_down,
   output logic carrier_sense_n
);
   // ----------------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------------
   if (OSC_HZ <= 0 || 2 * OSC_HZ > SYS_HZ || SYS_HZ >= (1 << 27)) begin : g_bad_rates
      $error("ftm_modulator: clock rates out of range");
   end

   localparam logic [`FTM_ACC_W-1:0] ACC_STEP = `FTM_ACC_W'(OSC_HZ);
   localparam logic [`FTM_ACC_W-1:0] ACC_WRAP = `FTM_ACC_W'(SYS_HZ);

   ftm_mode_type mode_q;
   ftm_mode_type mode_d;
   logic [`FTM_ACC_W-1:0] acc_q;
   logic [`FTM_ACC_W-1:0] acc_sum;
   logic osc_tick;
   logic [`FTM_DIV_W-1:0] div_cnt_q;
   logic [`FTM_DIV_W-1:0] divisor;
   logic tone_tick;
   logic running;
   logic [`FTM_PHASE_W-1:0] phase_q;
   logic [`FTM_DAC_W-1:0] rom_code;
   logic [`FTM_DAC_W-1:0] dac_q;
   logic drive_q;
   logic tx_high_q;
   logic rx_high_q;
   logic [`FTM_CD_W-1:0] cd_cnt_q;
   logic cd_n_q;

   // ----------------------------------------------------------------------
   // Mode control
   // ----------------------------------------------------------------------
   // Mode decode from the three control pins.
   always_comb begin
      if (loopback_sel && driver_squelch) begin
         mode_d = FTM_SHUTDOWN; // R9
      end else if (loopback_sel) begin
         mode_d = FTM_LOOPBACK; // R11
      end else if (orig_sel) begin
         mode_d = FTM_ORIGINATE; // R11
      end else begin
         mode_d = FTM_ANSWER;
      end
   end

   // Mode register.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mode_q <= FTM_SHUTDOWN;
      end else begin
         mode_q <= mode_d;
      end
   end

   assign running = (mode_q != FTM_SHUTDOWN);

   // Path configuration; loopback hears its own band.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tx_high_q <= 1'b0;
         rx_high_q <= 1'b0;
      end else begin
         case (mode_d)
            FTM_ORIGINATE: begin
               tx_high_q <= 1'b0; // R8
               rx_high_q <= 1'b1;
            end
            FTM_ANSWER: begin
               tx_high_q <= 1'b1; // R8
               rx_high_q <= 1'b0;
            end
            FTM_LOOPBACK: begin
               tx_high_q <= !orig_sel; // R8
               rx_high_q <= !orig_sel;
            end
            default: begin
               tx_high_q <= tx_high_q;
               rx_high_q <= rx_high_q;
            end
         endcase
      end
   end

   // Line driver enable; off under squelch and shutdown.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         drive_q <= 1'b0;
      end else begin
         drive_q <= !driver_squelch; // R10
      end
   end

   // ----------------------------------------------------------------------
   // Oscillator tick
   // ----------------------------------------------------------------------
   assign acc_sum = acc_q + ACC_STEP;
   assign osc_tick = running && (acc_sum >= ACC_WRAP); // R7

   // Fractional accumulator; the tick averages the crystal rate.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         acc_q <= '0;
      end else if (running) begin
         acc_q <= osc_tick ? acc_sum - ACC_WRAP : acc_sum; // R7
      end
   end

   // ----------------------------------------------------------------------
   // Dual-modulus tone divider
   // ----------------------------------------------------------------------
   // Divisor from band and bit.
   always_comb begin
      case ({tx_high_q, tx_bit})
         2'b01: divisor = `FTM_DIV_ORG_MARK; // R12
         2'b00: divisor = `FTM_DIV_ORG_SPACE; // R12
         2'b11: divisor = `FTM_DIV_ANS_MARK; // R12
         default: divisor = `FTM_DIV_ANS_SPACE; // R1
      endcase
   end

   assign tone_tick = osc_tick && (div_cnt_q == '0); // R2

   // Down counter reloaded with the divisor chosen at that moment.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         div_cnt_q <= '0;
      end else if (tone_tick) begin
         div_cnt_q <= divisor - `FTM_DIV_W'(1); // R1
      end else if (osc_tick) begin
         div_cnt_q <= div_cnt_q - `FTM_DIV_W'(1);
      end
   end

   // ----------------------------------------------------------------------
   // Slot counter and sine output
   // ----------------------------------------------------------------------
   // Phase only moves on a tone tick and is never cleared by a bit change.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         phase_q <= '0;
      end else if (tone_tick) begin
         phase_q <= phase_q + `FTM_PHASE_W'(1); // R3 R5
      end
   end

   ftm_sine_rom u_rom (
      .slot(phase_q),
      .code(rom_code)
   );

   // DAC code register; midscale while shut down.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dac_q <= `FTM_DAC_MID;
      end else begin
         dac_q <= running ? rom_code : `FTM_DAC_MID; // R4
      end
   end

   // ----------------------------------------------------------------------
   // Carrier qualifier
   // ----------------------------------------------------------------------
   // Counts oscillator ticks of continuous carrier, saturating at the delay.
   always_ff @(posedge clk_sys) begin
      if (srst || !running || !carrier_above) begin
         cd_cnt_q <= '0;
      end else if (osc_tick && cd_cnt_q < carrier_delay_cap) begin
         cd_cnt_q <= cd_cnt_q + `FTM_CD_W'(1); // R6
      end
   end

   // Active-low sense output; releases at once when the carrier drops.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cd_n_q <= 1'b1;
      end else begin
         cd_n_q <= !(running && carrier_above && cd_cnt_q >= carrier_delay_cap); // R6
      end
   end

   assign dac_code = dac_q;
   assign line_drive_en = drive_q && running;
   assign tx_band_high = tx_high_q;
   assign rx_band_high = rx_high_q;
   assign loop_active = (mode_q == FTM_LOOPBACK);
   assign power_down = !running;
   assign carrier_sense_n = cd_n_q;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   property p_div_reload;
      @(posedge clk_sys) disable iff (srst)
         tone_tick |=> div_cnt_q == $past(divisor) - `FTM_DIV_W'(1);
   endproperty
   a_div_reload: assert property (p_div_reload) else $error("divisor not reloaded"); // R1

   property p_mark_org;
      @(posedge clk_sys) disable iff (srst)
         (tone_tick && !tx_band_high && tx_bit) |=> div_cnt_q
            == `FTM_DIV_ORG_MARK - `FTM_DIV_W'(1);
   endproperty
   a_mark_org: assert property (p_mark_org) else $error("wrong originate mark divisor"); // R12
   property p_tick_on_osc;
      @(posedge clk_sys) disable iff (srst)
         tone_tick |-> osc_tick && running;
   endproperty
   a_tick_on_osc: assert property (p_tick_on_osc) else $error("tone tick off oscillator"); // R2 R7
   property p_phase_step;
      @(posedge clk_sys) disable iff (srst)
         tone_tick |=> phase_q == $past(phase_q) + `FTM_PHASE_W'(1);
   endproperty
   a_phase_step: assert property (p_phase_step) else $error("phase did not step"); // R3
   property p_dac_follow;
      @(posedge clk_sys) disable iff (srst)
         running |=> dac_code == $past(rom_code);
   endproperty
   a_dac_follow: assert property (p_dac_follow) else $error("dac code stale"); // R4
   property p_phase_hold;
      @(posedge clk_sys) disable iff (srst)
         ($changed(tx_bit) && !tone_tick) |=> $stable(phase_q);
   endproperty
   a_phase_hold: assert property (p_phase_hold) else $error("phase moved on bit change"); // R5
   property p_cd_qualified;
      @(posedge clk_sys) disable iff (srst)
         $fell(carrier_sense_n) |-> $past(cd_cnt_q) >= $past(carrier_delay_cap)
            && $past(carrier_above);
   endproperty
   a_cd_qualified: assert property (p_cd_qualified) else $error("carrier sense early"); // R6
   property p_cd_release;
      @(posedge clk_sys) disable iff (srst)
         !carrier_above |=> carrier_sense_n;
   endproperty
   a_cd_release: assert property (p_cd_release) else $error("carrier sense held"); // R6
   property p_loopback;
      @(posedge clk_sys) disable iff (srst)
         (loopback_sel && !driver_squelch) |=> loop_active && tx_band_high == rx_band_high;
   endproperty
   a_loopback: assert property (p_loopback) else $error("loopback not entered"); // R8 R11

   property p_shutdown;
      @(posedge clk_sys) disable iff (srst)
         (loopback_sel && driver_squelch) |=> (power_down && !line_drive_en)
            ##1 (dac_code == `FTM_DAC_MID);
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("shutdown not entered"); // R9

   property p_squelch;
      @(posedge clk_sys) disable iff (srst)
         driver_squelch |=> !line_drive_en;
   endproperty
   a_squelch: assert property (p_squelch) else $error("driver not squelched"); // R10

   c_tone: cover property (@(posedge clk_sys) disable iff (srst) tone_tick && phase_q == 4'hF);
   c_cd: cover property (@(posedge clk_sys) disable iff (srst) $fell(carrier_sense_n));
   c_bit: cover property (@(posedge clk_sys) disable iff (srst) running && $changed(tx_bit));
endmodule
`default_nettype wire

// file: design/ftm_consts.svh
// Constant values shared by the tone modulator design files.
`ifndef FTM_CONSTS_SVH
`define FTM_CONSTS_SVH

// ----------------------------------------------------------------------
// Clock rates
// ----------------------------------------------------------------------
`define FTM_SYS_HZ 125000000
`define FTM_OSC_HZ 3579545
`define FTM_ACC_W 28

// ----------------------------------------------------------------------
// Tone divisors in oscillator ticks, for sixteen slots per tone period
// ----------------------------------------------------------------------
`define FTM_DIV_W 8
`define FTM_DIV_ORG_MARK 8'hB0
`define FTM_DIV_ORG_SPACE 8'hD1
`define FTM_DIV_ANS_MARK 8'h65
`define FTM_DIV_ANS_SPACE 8'h6E

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define FTM_PHASE_W 4
`define FTM_DAC_W 8
`define FTM_DAC_MID 8'h80
`define FTM_CD_W 16

`endif

// file: design/ftm_pkg.sv
// Types shared by the tone modulator design files.
`default_nettype none
package ftm_pkg;
   // Operating modes chosen from the mode pins.
   typedef enum logic [1:0] {
      FTM_ORIGINATE,
      FTM_ANSWER,
      FTM_LOOPBACK,
      FTM_SHUTDOWN
   } ftm_mode_type;
endpackage
`default_nettype wire

// file: design/ftm_sine_rom.sv
// Sixteen-entry staircase sine table in offset binary.
`default_nettype none
module ftm_sine_rom (
   input wire logic [3:0] slot,
   output logic [7:0] code
);
   // One code per time slot, centred on midscale.
   always_comb begin
      case (slot)
         4'h0: code = 8'h80;
         4'h1: code = 8'hB1;
         4'h2: code = 8'hDA;
         4'h3: code = 8'hF5;
         4'h4: code = 8'hFF;
         4'h5: code = 8'hF5;
         4'h6: code = 8'hDA;
         4'h7: code = 8'hB1;
         4'h8: code = 8'h80;
         4'h9: code = 8'h4F;
         4'hA: code = 8'h26;
         4'hB: code = 8'h0B;
         4'hC: code = 8'h01;
         4'hD: code = 8'h0B;
         4'hE: code = 8'h26;
         4'hF: code = 8'h4F;
         default: code = 8'h80;
      endcase
   end
endmodule
`default_nettype wire

// file: verif/ftm_host_model.sv
// Host model that drives the mode pins and the transmit bit stream.
`default_nettype none
module ftm_host_model (
   input wire logic orig_req,
   input wire logic loop_req,
   input wire logic hush_req,
   input wire logic down_req,
   input wire logic bit_req,
   output logic orig_sel,
   output logic loopback_sel,
   output logic driver_squelch,
   output logic tx_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   // Shutdown is only ever requested by raising loopback and squelch together.
   assign loopback_sel = loop_req | down_req;
   assign driver_squelch = hush_req | down_req;
   // Band select and data pass straight through from the host sequencer.
   assign orig_sel = orig_req;
   assign tx_bit = bit_req;
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the FSK tone modulator.
`include "ftm_consts.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import ftm_pkg::*;
   // ----------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------
   localparam int OSC = 31250000;
   localparam int TPO = 125000000 / OSC; // System clocks per oscillator tick.
   logic clk_sys, srst, carrier_above, orig_req, loop_req, hush_req, down_req, bit_req;
   logic tx_bit, orig_sel, loopback_sel, driver_squelch;
   logic [15:0] carrier_delay_cap;
   logic [7:0] dac_code;
   logic line_drive_en, tx_band_high, rx_band_high, loop_active, power_down, carrier_sense_n;
   int bad_count = 0;
   int tests_run = 0;
   logic [7:0] tbl [16] = '{8'h80, 8'hB1, 8'hDA, 8'hF5, 8'hFF, 8'hF5, 8'hDA, 8'hB1,
                            8'h80, 8'h4F, 8'h26, 8'h0B, 8'h01, 8'h0B, 8'h26, 8'h4F};

   ftm_host_model i_ftm_host_model (.orig_req(orig_req), .loop_req(loop_req),
      .hush_req(hush_req), .down_req(down_req), .bit_req(bit_req), .orig_sel(orig_sel),
      .loopback_sel(loopback_sel), .driver_squelch(driver_squelch), .tx_bit(tx_bit));

   ftm_modulator #(.OSC_HZ(OSC)) i_ftm_modulator (.clk_sys(clk_sys), .srst(srst),
      .tx_bit(tx_bit), .orig_sel(orig_sel), .loopback_sel(loopback_sel),
      .driver_squelch(driver_squelch), .carrier_above(carrier_above),
      .carrier_delay_cap(carrier_delay_cap), .dac_code(dac_code),
      .line_drive_en(line_drive_en), .tx_band_high(tx_band_high),
      .rx_band_high(rx_band_high), .loop_active(loop_active), .power_down(power_down),
      .carrier_sense_n(carrier_sense_n));

   // Free-running system clock at 125 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Counts cycles until the DAC code moves, with a bound against a stuck divider.
   task automatic wait_step(output int n);
      logic [7:0] last;
      n = 0;
      last = dac_code;
      do begin
         @(negedge clk_sys);
         n++;
      end while (dac_code === last && n < 4000);
   endtask

   task automatic test_done();
      $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic test_modes();
      for (int i = 0; i < 4; i++) begin
         orig_req = i[0];
         loop_req = i[1];
         repeat (2) @(negedge clk_sys);
         check(loop_active, i[1]);
         check(tx_band_high, !i[0]);
         check(rx_band_high, i[1] ? !i[0] : i[0]);
         check({power_down, line_drive_en}, 2'b01);
      end
      loop_req = 1'b0;
      hush_req = 1'b1;
      repeat (2) @(negedge clk_sys);
      check({power_down, line_drive_en}, 2'b00);
      hush_req = 1'b0;
      down_req = 1'b1;
      repeat (3) @(negedge clk_sys);
      check({power_down, line_drive_en, loop_active, tx_band_high}, 4'b1000);
      check(dac_code, `FTM_DAC_MID);
      down_req = 1'b0;
      repeat (2) @(negedge clk_sys);
      check({power_down, line_drive_en}, 2'b01);
   endtask

   // Slot length is the divisor in oscillator ticks for each bit and band.
   task automatic test_tones();
      int n;
      int div [4] = '{`FTM_DIV_ANS_SPACE, `FTM_DIV_ANS_MARK, `FTM_DIV_ORG_SPACE,
                      `FTM_DIV_ORG_MARK};
      for (int i = 0; i < 4; i++) begin
         orig_req = i[1];
         bit_req = i[0];
         repeat (3) wait_step(n);
         check(16'(n), 16'(TPO * div[i]));
      end
   endtask

   // Walks one whole sine period from the unique peak code; ends on the peak again.
   task automatic test_sequence();
      int n;
      for (int k = 0; k < 17 && dac_code !== 8'hFF; k++) wait_step(n);
      check(dac_code, 8'hFF);
      for (int k = 5; k < 21; k++) begin
         wait_step(n);
         check(dac_code, tbl[k % 16]);
      end
   endtask

   // A bit change mid-slot keeps the staircase going and only alters the next slot.
   task automatic test_phase();
      int n;
      bit_req = 1'b0;
      wait_step(n);
      check(16'(n), 16'(TPO * `FTM_DIV_ORG_MARK));
      check(dac_code, 8'hF5);
      wait_step(n);
      check(16'(n), 16'(TPO * `FTM_DIV_ORG_SPACE));
      check(dac_code, 8'hDA);
   endtask

   task automatic test_carrier(input logic [15:0] cap);
      carrier_delay_cap = cap;
      carrier_above = 1'b1;
      repeat (TPO * cap - TPO) @(negedge clk_sys);
      check(carrier_sense_n, 1'b1);
      repeat (2 * TPO + 2) @(negedge clk_sys);
      check(carrier_sense_n, 1'b0);
      carrier_above = 1'b0;
      repeat (2) @(negedge clk_sys);
      check(carrier_sense_n, 1'b1);
   endtask

   // ----------------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------------
   initial begin
      srst = 1'b1;
      carrier_above = 1'b0;
      carrier_delay_cap = 16'h0008;
      orig_req = 1'b1;
      loop_req = 1'b0;
      hush_req = 1'b0;
      down_req = 1'b0;
      bit_req = 1'b1;
      repeat (10) @(negedge clk_sys);
      check({power_down, line_drive_en, loop_active, carrier_sense_n}, 4'b1001);
      check({tx_band_high, rx_band_high, dac_code}, {2'b00, `FTM_DAC_MID});
      srst = 1'b0;
      test_modes();
      test_tones();
      test_sequence();
      test_phase();
      carrier_above = 1'b1;
      repeat (20) @(negedge clk_sys);
      check(carrier_sense_n, 1'b1);
      carrier_above = 1'b0;
      @(negedge clk_sys);
      test_carrier(16'h0008);
      test_carrier(16'h0002);
      test_done();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (60000) @(posedge clk_sys);
      bad_count++;
      test_done();
   end
endmodule
`default_nettype wire
